// ---- pkg/bp_match_pkg.sv ----
package bp_match_pkg;

    // Trigger count and field geometry of the match control word.
    localparam int NUM_TRIG = 8;
    localparam int SEL_W = 3;
    localparam int LOAD_BIT = 0;
    localparam int STORE_BIT = 1;
    localparam int FETCH_BIT = 2;
    localparam int USER_BIT = 3;
    localparam int SUPER_BIT = 4;
    localparam int MACH_BIT = 6;
    localparam int MATCH_LSB = 7;
    localparam int MATCH_MSB = 10;
    localparam int CHAIN_BIT = 11;
    localparam int ACTION_LSB = 12;
    localparam int ACTION_MSB = 17;
    localparam int TIMING_BIT = 18;
    localparam int SELECT_BIT = 19;
    localparam int MASKMAX_LSB = 21;
    localparam int MASKMAX_MSB = 26;
    localparam int DMODE_BIT = 27;
    localparam int TYPE_LSB = 28;
    localparam int TYPE_MSB = 31;

    // Fixed and default values.
    localparam logic [3:0] TYPE_ADDR_MATCH = 4'h2;
    localparam logic [3:0] TYPE_ABSENT = 4'h0;
    localparam logic [5:0] MASKMAX_VAL = 6'h04;
    localparam int MASKMAX_DEF = 4;

    // Range kinds held in the match field.
    localparam logic [3:0] MATCH_EXACT = 4'h0;
    localparam logic [3:0] MATCH_NAPOT = 4'h1;
    localparam logic [3:0] MATCH_GE = 4'h2;
    localparam logic [3:0] MATCH_LT = 4'h3;

    // Actions on a successful match.
    localparam logic [5:0] ACT_EXCEPTION = 6'h00;
    localparam logic [5:0] ACT_DEBUG = 6'h01;

    // Privilege encodings.
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_MACH = 2'h3;

    // Register selector of the CSR access port.
    localparam logic [1:0] CSR_SELECT = 2'h0;
    localparam logic [1:0] CSR_WORD_ONE = 2'h1;
    localparam logic [1:0] CSR_WORD_TWO = 2'h2;
    localparam logic [1:0] CSR_WORD_THREE = 2'h3;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] sel;
        logic [31:0] wdata;
    } csr_req_t;

    typedef struct packed {
        logic valid;
        logic load;
        logic store;
        logic fetch;
        logic [1:0] priv;
        logic [31:0] addr;
    } access_t;

    typedef struct packed {
        logic loadEn;
        logic storeEn;
        logic fetchEn;
        logic userEn;
        logic superEn;
        logic machEn;
        logic [3:0] matchKind;
        logic chain;
        logic [5:0] action;
        logic dmode;
        logic [31:0] addr;
    } trig_cfg_t;

endpackage : bp_match_pkg

// ---- core/trig_compare.sv ----
`timescale 1ns/10ps
module trig_compare #(
    parameter int MASKMAX = bp_match_pkg::MASKMAX_DEF
) (
    // Trigger setup
    input wire bp_match_pkg::trig_cfg_t cfg,
    // Access under test
    input wire bp_match_pkg::access_t acc,
    // Result
    output logic hit
);

    logic kindOk;
    logic privOk;
    logic addrOk;
    logic [31:0] careMask;
    logic [MASKMAX-1:0] napotIgnore;

    // Trailing ones of the address word, below the lowest zero, widen the
    // ignored low bits; the run is cut at the largest supported range.
    assign napotIgnore[0] = 1'b1;
    genvar j;
    generate
        for (j = 1; j < MASKMAX; j++)
        begin : g_mask
            assign napotIgnore[j] = napotIgnore[j-1] & cfg.addr[j-1];
        end
    endgenerate

    always_comb
    begin
        careMask = '1;
        if (cfg.matchKind == bp_match_pkg::MATCH_NAPOT)
        begin
            careMask[MASKMAX-1:0] = ~napotIgnore;
        end
    end

    assign kindOk = (cfg.loadEn & acc.load) | (cfg.storeEn & acc.store)
        | (cfg.fetchEn & acc.fetch);
    assign privOk = (cfg.userEn & (acc.priv == bp_match_pkg::PRIV_USER))
        | (cfg.superEn & (acc.priv == bp_match_pkg::PRIV_SUPER))
        | (cfg.machEn & (acc.priv == bp_match_pkg::PRIV_MACH));

    always_comb
    begin
        case (cfg.matchKind)
            bp_match_pkg::MATCH_EXACT: addrOk = (acc.addr == cfg.addr);
            bp_match_pkg::MATCH_NAPOT:
                addrOk = ((acc.addr ^ cfg.addr) & careMask) == 32'h0;
            bp_match_pkg::MATCH_GE: addrOk = (acc.addr >= cfg.addr);
            bp_match_pkg::MATCH_LT: addrOk = (acc.addr < cfg.addr);
            default: addrOk = 1'b0;
        endcase
    end

    assign hit = acc.valid & kindOk & privOk & addrOk;

endmodule : trig_compare

// ---- core/breakpoint_match_control.sv ----
`timescale 1ns/10ps
module breakpoint_match_control #(
    parameter int NUM_TRIG = bp_match_pkg::NUM_TRIG,
    parameter int MASKMAX = bp_match_pkg::MASKMAX_DEF
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Hart mode
    input wire logic debugMode,
    // CSR access port
    input wire bp_match_pkg::csr_req_t csrReq,
    output logic csrDone_ff,
    output logic csrIllegal_ff,
    output logic [31:0] csrRdata_ff,
    // Pipeline access to check
    input wire bp_match_pkg::access_t access,
    // Match result
    output logic bpException_ff,
    output logic bpDebugEnter_ff,
    output logic [NUM_TRIG-1:0] bpFire_ff
);

    localparam int SEL_W = bp_match_pkg::SEL_W;

    bp_match_pkg::trig_cfg_t cfg_ff [NUM_TRIG];
    logic [SEL_W-1:0] select_ff;
    logic [NUM_TRIG-1:0] hit;
    logic [NUM_TRIG-1:0] fire;
    logic [31:0] curWord;
    logic blocked;
    logic accessOk;
    logic wrOne;
    logic wrTwo;
    bp_match_pkg::trig_cfg_t curCfg;

    assign curCfg = cfg_ff[select_ff];

    // A machine-mode touch of a debug-owned trigger's data words is refused.
    assign blocked = !debugMode && curCfg.dmode
        && (csrReq.sel != bp_match_pkg::CSR_SELECT);
    assign accessOk = clkEn && csrReq.valid && !blocked;
    assign wrOne = accessOk && csrReq.write
        && (csrReq.sel == bp_match_pkg::CSR_WORD_ONE);
    assign wrTwo = accessOk && csrReq.write
        && (csrReq.sel == bp_match_pkg::CSR_WORD_TWO);

    // Control word as read back; fixed fields are constants.
    always_comb
    begin
        curWord = 32'h0;
        curWord[bp_match_pkg::LOAD_BIT] = curCfg.loadEn;
        curWord[bp_match_pkg::STORE_BIT] = curCfg.storeEn;
        curWord[bp_match_pkg::FETCH_BIT] = curCfg.fetchEn;
        curWord[bp_match_pkg::USER_BIT] = curCfg.userEn;
        curWord[bp_match_pkg::SUPER_BIT] = curCfg.superEn;
        curWord[bp_match_pkg::MACH_BIT] = curCfg.machEn;
        curWord[bp_match_pkg::MATCH_MSB:bp_match_pkg::MATCH_LSB] =
            curCfg.matchKind;
        curWord[bp_match_pkg::CHAIN_BIT] = curCfg.chain;
        curWord[bp_match_pkg::ACTION_MSB:bp_match_pkg::ACTION_LSB] =
            curCfg.action;
        curWord[bp_match_pkg::MASKMAX_MSB:bp_match_pkg::MASKMAX_LSB] =
            bp_match_pkg::MASKMAX_VAL;
        curWord[bp_match_pkg::DMODE_BIT] = curCfg.dmode;
        if (!debugMode && curCfg.dmode)
        begin
            curWord[bp_match_pkg::TYPE_MSB:bp_match_pkg::TYPE_LSB] =
                bp_match_pkg::TYPE_ABSENT;
        end
        else
        begin
            curWord[bp_match_pkg::TYPE_MSB:bp_match_pkg::TYPE_LSB] =
                bp_match_pkg::TYPE_ADDR_MATCH;
        end
    end

    // The select index only takes values of implemented triggers.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            select_ff <= '0;
        end
        else if (accessOk && csrReq.write
            && (csrReq.sel == bp_match_pkg::CSR_SELECT)
            && (csrReq.wdata < 32'(NUM_TRIG)))
        begin
            select_ff <= csrReq.wdata[SEL_W-1:0];
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_TRIG; i++)
        begin : g_trig
            logic [5:0] wAct;
            logic [3:0] wMatch;
            logic selHere;

            assign selHere = (select_ff == SEL_W'(i));
            assign wAct = csrReq.wdata[bp_match_pkg::ACTION_MSB:
                bp_match_pkg::ACTION_LSB];
            assign wMatch = csrReq.wdata[bp_match_pkg::MATCH_MSB:
                bp_match_pkg::MATCH_LSB];

            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    cfg_ff[i] <= '0;
                end
                else if (wrOne && selHere)
                begin
                    cfg_ff[i].loadEn <= csrReq.wdata[bp_match_pkg::LOAD_BIT];
                    cfg_ff[i].storeEn <=
                        csrReq.wdata[bp_match_pkg::STORE_BIT];
                    cfg_ff[i].fetchEn <=
                        csrReq.wdata[bp_match_pkg::FETCH_BIT];
                    cfg_ff[i].userEn <= csrReq.wdata[bp_match_pkg::USER_BIT];
                    cfg_ff[i].superEn <=
                        csrReq.wdata[bp_match_pkg::SUPER_BIT];
                    cfg_ff[i].machEn <= csrReq.wdata[bp_match_pkg::MACH_BIT];
                    cfg_ff[i].chain <= csrReq.wdata[bp_match_pkg::CHAIN_BIT];
                    // Unsupported codes leave the field as it was.
                    if (wMatch <= bp_match_pkg::MATCH_LT)
                    begin
                        cfg_ff[i].matchKind <= wMatch;
                    end
                    if (wAct <= bp_match_pkg::ACT_DEBUG)
                    begin
                        cfg_ff[i].action <= wAct;
                    end
                    // Only debug code may claim or release a trigger.
                    if (debugMode)
                    begin
                        cfg_ff[i].dmode <=
                            csrReq.wdata[bp_match_pkg::DMODE_BIT];
                    end
                end
                else if (wrTwo && selHere)
                begin
                    cfg_ff[i].addr <= csrReq.wdata;
                end
            end

            trig_compare #(
                .MASKMAX(MASKMAX)
            ) u_cmp (
                .cfg(cfg_ff[i]),
                .acc(access),
                .hit(hit[i])
            );

            // A chained trigger only qualifies its upper neighbour.
            if (i == 0)
            begin : g_first
                assign fire[i] = hit[i] && !cfg_ff[i].chain;
            end
            else
            begin : g_rest
                assign fire[i] = hit[i] && !cfg_ff[i].chain
                    && (!cfg_ff[i-1].chain || hit[i-1]);
            end
        end
    endgenerate

    // CSR answer one cycle after the request.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            csrDone_ff <= 1'b0;
            csrIllegal_ff <= 1'b0;
            csrRdata_ff <= 32'h0;
        end
        else if (clkEn)
        begin
            csrDone_ff <= csrReq.valid;
            csrIllegal_ff <= csrReq.valid && blocked;
            if (!csrReq.valid || blocked)
            begin
                csrRdata_ff <= 32'h0;
            end
            else
            begin
                case (csrReq.sel)
                    bp_match_pkg::CSR_SELECT:
                        csrRdata_ff <= 32'(select_ff);
                    bp_match_pkg::CSR_WORD_ONE: csrRdata_ff <= curWord;
                    bp_match_pkg::CSR_WORD_TWO: csrRdata_ff <= curCfg.addr;
                    default: csrRdata_ff <= 32'h0;
                endcase
            end
        end
    end

    // Triggers stay quiet while the hart is already in debug mode, so that
    // debug code cannot trap on its own accesses.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bpException_ff <= 1'b0;
            bpDebugEnter_ff <= 1'b0;
            bpFire_ff <= '0;
        end
        else if (clkEn)
        begin
            bpException_ff <= 1'b0;
            bpDebugEnter_ff <= 1'b0;
            bpFire_ff <= debugMode ? '0 : fire;
            if (!debugMode)
            begin
                for (int k = 0; k < NUM_TRIG; k++)
                begin
                    if (fire[k] && cfg_ff[k].action == bp_match_pkg::ACT_DEBUG)
                    begin
                        bpDebugEnter_ff <= 1'b1;
                    end
                end
                // Debug entry takes priority over the exception.
                if (|fire)
                begin
                    bpException_ff <= 1'b1;
                    for (int k = 0; k < NUM_TRIG; k++)
                    begin
                        if (fire[k]
                            && cfg_ff[k].action == bp_match_pkg::ACT_DEBUG)
                        begin
                            bpException_ff <= 1'b0;
                        end
                    end
                end
            end
        end
    end

endmodule : breakpoint_match_control

// ---- verification/bp_match_monitor.sv ----
`timescale 1ns/10ps
module bp_match_monitor #(
    parameter int NUM_TRIG = bp_match_pkg::NUM_TRIG,
    parameter int MASKMAX = bp_match_pkg::MASKMAX_DEF
) (
    // Clock, reset and mode
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic debugMode,
    // CSR port
    input wire bp_match_pkg::csr_req_t csrReq,
    input wire logic csrDone_ff,
    input wire logic csrIllegal_ff,
    input wire logic [31:0] csrRdata_ff,
    // Match path
    input wire bp_match_pkg::access_t access,
    input wire logic bpException_ff,
    input wire logic bpDebugEnter_ff,
    input wire logic [NUM_TRIG-1:0] bpFire_ff
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // A frozen edge holds every output, so an answer is only paired with a
    // request that met an enabled edge.
    logic ctrlRead;
    logic selRead;
    assign ctrlRead = clkEn && csrReq.valid && !csrReq.write
        && csrReq.sel == 2'h1;
    assign selRead = clkEn && csrReq.valid && !csrReq.write
        && csrReq.sel == 2'h0;

    a_done_pairs_req: assert property ($past(clkEn)
        |-> csrDone_ff == $past(csrReq.valid))
        else $error("csr answer not one cycle after request");
    a_ctrl_fixed_fields: assert property (
        $past(ctrlRead) && !csrIllegal_ff
        |-> csrRdata_ff[31:28] == 4'h2 && csrRdata_ff[26:21] == 6'h04
        && csrRdata_ff[20:18] == 3'h0 && !csrRdata_ff[5])
        else $error("fixed control fields read wrong");
    a_action_legal: assert property ($past(ctrlRead)
        |-> csrRdata_ff[17:12] <= 6'h01)
        else $error("action field holds an unsupported code");
    a_match_legal: assert property ($past(ctrlRead)
        |-> csrRdata_ff[10:7] <= 4'h3)
        else $error("match field holds an unsupported code");
    a_one_action: assert property ((|bpFire_ff)
        |-> bpException_ff != bpDebugEnter_ff)
        else $error("fired trigger without exactly one action");
    a_no_action_idle: assert property (!(|bpFire_ff)
        |-> !bpException_ff && !bpDebugEnter_ff)
        else $error("action raised with no trigger fired");
    a_quiet_no_access: assert property (
        $past(clkEn && (debugMode || !access.valid))
        |-> bpFire_ff == '0)
        else $error("trigger fired without a checked access");
    a_illegal_shape: assert property (csrIllegal_ff
        |-> csrDone_ff && csrRdata_ff == 32'h0)
        else $error("illegal answer malformed");
    a_illegal_cause: assert property (csrIllegal_ff && $past(clkEn)
        |-> $past(!debugMode && csrReq.sel != 2'h0))
        else $error("illegal answer without machine data access");
    a_select_range: assert property ($past(selRead)
        |-> !csrIllegal_ff && csrRdata_ff < NUM_TRIG)
        else $error("select index out of range or refused");
endmodule : bp_match_monitor

bind breakpoint_match_control bp_match_monitor #(
    .NUM_TRIG(NUM_TRIG),
    .MASKMAX(MASKMAX)
) mon (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .debugMode(debugMode),
    .csrReq(csrReq),
    .csrDone_ff(csrDone_ff),
    .csrIllegal_ff(csrIllegal_ff),
    .csrRdata_ff(csrRdata_ff),
    .access(access),
    .bpException_ff(bpException_ff),
    .bpDebugEnter_ff(bpDebugEnter_ff),
    .bpFire_ff(bpFire_ff)
);

// ---- verification/pipe_access_model.sv ----
`timescale 1ns/10ps
module pipe_access_model (
    // Clock
    input wire logic ref_clk,
    // Access toward the block
    output bp_match_pkg::access_t acc
);
    initial acc = '0;

    task automatic issue(input logic [2:0] lsf, input logic [1:0] pr,
        input logic [31:0] a);
        @(posedge ref_clk);
        acc <= {1'b1, lsf, pr, a};
        @(posedge ref_clk);
        // Idle shows the inverted address so a stale value cannot pass.
        acc <= {1'b0, 3'h0, 2'h0, ~a};
    endtask : issue
endmodule : pipe_access_model

// ---- verification/breakpoint_match_control_bench.sv ----
`timescale 1ns/10ps
module breakpoint_match_control_bench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    logic debugMode = 1'b0;
    bp_match_pkg::csr_req_t csrReq = '0;
    bp_match_pkg::access_t access;
    logic csrDone_ff, csrIllegal_ff, bpException_ff, bpDebugEnter_ff;
    logic [31:0] csrRdata_ff;
    logic [7:0] bpFire_ff;
    logic [9:0] expRes;
    logic [31:0] oldCtl = 32'h2080_0000;
    logic [31:0] kindEn [3] = '{32'h1, 32'h2, 32'h4};
    logic [31:0] privEn [3] = '{32'h8, 32'h10, 32'h40};
    logic [1:0] privCode [3] = '{2'h0, 2'h1, 2'h3};
    int failures = 0;
    int samplesChecked = 0;

    always #20 ref_clk = ~ref_clk;

    breakpoint_match_control #(.NUM_TRIG(8), .MASKMAX(4)) uut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .debugMode(debugMode),
        .csrReq(csrReq),
        .csrDone_ff(csrDone_ff),
        .csrIllegal_ff(csrIllegal_ff),
        .csrRdata_ff(csrRdata_ff),
        .access(access),
        .bpException_ff(bpException_ff),
        .bpDebugEnter_ff(bpDebugEnter_ff),
        .bpFire_ff(bpFire_ff)
    );

    pipe_access_model pipe (
        .ref_clk(ref_clk),
        .acc(access)
    );

    task automatic chk(input string what, input logic [31:0] expv,
        input logic [31:0] got);
        samplesChecked++;
        if (got !== expv)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, expv, got);
        end
    endtask : chk

    task automatic csr(input logic w, input logic [1:0] s,
        input logic [31:0] d, input logic [31:0] er, input logic ei);
        @(posedge ref_clk);
        csrReq <= {1'b1, w, s, d};
        @(posedge ref_clk);
        csrReq <= '0;
        #1;
        chk("csr done", 32'h1, {31'h0, csrDone_ff});
        chk("csr illegal", {31'h0, ei}, {31'h0, csrIllegal_ff});
        chk("csr rdata", er, csrRdata_ff);
    endtask : csr

    task automatic prog(input logic [2:0] idx, input logic [31:0] ctl,
        input logic [31:0] a, input logic [31:0] os, input logic [31:0] oc,
        input logic [31:0] oa);
        // A write answers with the word that it replaces.
        csr(1'b1, 2'h0, {29'h0, idx}, os, 1'b0);
        csr(1'b1, 2'h1, ctl, oc, 1'b0);
        csr(1'b1, 2'h2, a, oa, 1'b0);
    endtask : prog

    task automatic hit(input logic [2:0] lsf, input logic [1:0] pr,
        input logic [31:0] a, input logic [9:0] e);
        pipe.issue(lsf, pr, a);
        #1;
        chk("match result", {22'h0, e},
            {22'h0, bpFire_ff, bpException_ff, bpDebugEnter_ff});
    endtask : hit

    task automatic tally_and_finish;
        if (failures == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #100000;
        failures++;
        tally_and_finish;
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        csr(1'b0, 2'h1, 32'h0, 32'h2080_0000, 1'b0);
        csr(1'b1, 2'h1, 32'hffff_ffff, 32'h2080_0000, 1'b0);
        csr(1'b0, 2'h1, 32'h0, 32'h2080_085f, 1'b0);
        csr(1'b1, 2'h1, 32'h0, 32'h2080_085f, 1'b0);
        csr(1'b1, 2'h0, 32'h8, 32'h0, 1'b0);
        csr(1'b0, 2'h0, 32'h0, 32'h0, 1'b0);
        for (int a = 0; a < 3; a++)
        begin
            prog(3'h1, kindEn[a] | privEn[a], 32'h100, {31'h0, a != 0},
                oldCtl, (a != 0) ? 32'h100 : 32'h0);
            oldCtl = 32'h2080_0000 | kindEn[a] | privEn[a];
            for (int b = 0; b < 3; b++)
            begin
                expRes = (a == b) ? 10'h00a : 10'h000;
                hit(3'b100 >> b, privCode[a], 32'h100, expRes);
                hit(3'b100 >> a, privCode[b], 32'h100, expRes);
            end
        end
        hit(3'b001, 2'h3, 32'h101, 10'h000);
        csr(1'b1, 2'h1, 32'h0000_1044, oldCtl, 1'b0);
        hit(3'b001, 2'h3, 32'h100, 10'h009);
        csr(1'b1, 2'h1, 32'h0000_2044, 32'h2080_1044, 1'b0);
        csr(1'b0, 2'h1, 32'h0, 32'h2080_1044, 1'b0);
        csr(1'b1, 2'h1, 32'h0, 32'h2080_1044, 1'b0);
        prog(3'h2, 32'h0000_00c1, 32'h203, 32'h1, 32'h2080_0000, 32'h0);
        hit(3'b100, 2'h3, 32'h200, 10'h012);
        hit(3'b100, 2'h3, 32'h207, 10'h012);
        hit(3'b100, 2'h3, 32'h208, 10'h000);
        csr(1'b1, 2'h2, 32'h0000_ffff, 32'h203, 1'b0);
        csr(1'b0, 2'h2, 32'h0, 32'h0000_ffff, 1'b0);
        hit(3'b100, 2'h3, 32'hfff0, 10'h012);
        hit(3'b100, 2'h3, 32'hffef, 10'h000);
        csr(1'b1, 2'h1, 32'h0, 32'h2080_00c1, 1'b0);
        prog(3'h3, 32'h0000_0941, 32'h400, 32'h2, 32'h2080_0000, 32'h0);
        prog(3'h4, 32'h0000_01c1, 32'h410, 32'h3, 32'h2080_0000, 32'h0);
        hit(3'b100, 2'h3, 32'h40f, 10'h042);
        hit(3'b100, 2'h3, 32'h400, 10'h042);
        hit(3'b100, 2'h3, 32'h410, 10'h000);
        hit(3'b100, 2'h3, 32'h3ff, 10'h000);
        // A frozen clock must swallow an access that would otherwise fire.
        @(posedge ref_clk);
        clkEn <= 1'b0;
        hit(3'b100, 2'h3, 32'h40f, 10'h000);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        hit(3'b100, 2'h3, 32'h40f, 10'h042);
        csr(1'b1, 2'h3, 32'hffff_ffff, 32'h0, 1'b0);
        csr(1'b0, 2'h3, 32'h0, 32'h0, 1'b0);
        @(posedge ref_clk);
        debugMode <= 1'b1;
        prog(3'h5, 32'h0800_0041, 32'h500, 32'h4, 32'h2080_0000, 32'h0);
        csr(1'b0, 2'h1, 32'h0, 32'h2880_0041, 1'b0);
        hit(3'b100, 2'h3, 32'h500, 10'h000);
        @(posedge ref_clk);
        debugMode <= 1'b0;
        csr(1'b0, 2'h1, 32'h0, 32'h0, 1'b1);
        csr(1'b1, 2'h2, 32'h0, 32'h0, 1'b1);
        csr(1'b0, 2'h0, 32'h0, 32'h5, 1'b0);
        tally_and_finish;
    end
endmodule : breakpoint_match_control_bench
